/* dli_params.svh */
`ifndef DLI_PARAMS_SVH
`define DLI_PARAMS_SVH

// Register indices; byte address on the bus is four times the index
`define DLI_IDX_CTL0        3'h0
`define DLI_IDX_CTL1        3'h1
`define DLI_IDX_ERRSTAT     3'h2
`define DLI_IDX_IRQSTAT     3'h3
`define DLI_IDX_ATTR        3'h4
`define DLI_IDX_TADDR       3'h5
`define DLI_IDX_DATAHI      3'h6
`define DLI_IDX_DATALO      3'h7

// Address regions, selected by address[11:10]
`define DLI_REGION_REGS     2'h0
`define DLI_REGION_BLOCKING 2'h1
`define DLI_REGION_NONBLOCK 2'h2
`define DLI_REGS_LIMIT      8'h08

// Field positions
`define DLI_BIT_ENABLE      7
`define DLI_BIT_WIDE        6
`define DLI_BIT_HALTWAIT    5
`define DLI_BIT_IRQ_ENABLE  7
`define DLI_BIT_ERR_FLAG    7
`define DLI_BIT_IRQ_FLAG    7
`define DLI_TIMEOUT_MSB     3
`define DLI_DIV_MSB         1

// Reset values and readable-bit masks
`define DLI_CTL0_RESET      8'h00
`define DLI_CTL1_RESET      8'h00
`define DLI_CTL0_RDMASK     8'hE3
`define DLI_CTL1_RDMASK     8'h8F

// Timing: bus clock is clk/2, link clock high phase is half a bus period
`define DLI_CLK_PERIOD_NS   8
`define DLI_BUS_PERIOD_NS   16
`define DLI_HIGH_NS         8
`define DLI_BUS_CYC   ((`DLI_BUS_PERIOD_NS + `DLI_CLK_PERIOD_NS - 1) / `DLI_CLK_PERIOD_NS)
`define DLI_HIGH_CYC  ((`DLI_HIGH_NS + `DLI_CLK_PERIOD_NS - 1) / `DLI_CLK_PERIOD_NS)

`endif

/* dli_pkg.sv */
package dli_pkg;

    typedef enum logic [1:0] {
        DLI_IDLE   = 2'h0,
        DLI_WINDOW = 2'h1,
        DLI_ANSWER = 2'h3
    } dli_bus_state_e;

    typedef struct packed {
        logic       linkClockOut;
        logic       ownClock;
        logic [7:0] linkDataLinesOut;
        logic [7:0] linkDataLinesOeN;
        logic [7:0] linkDataPullDown;
        logic [7:0] ownData;
        logic       ownIrq;
        logic       irqPullDown;
    } dli_pins_s;

    typedef struct packed {
        logic       linkEnable;
        logic       linkWidthSel;
        logic       haltInWait;
        logic [1:0] linkClockDivider;
        logic       irqEnable;
        logic [3:0] timeout;
        logic       linkHalted;
    } dli_cfg_s;

    typedef struct packed {
        logic [7:0] errStatus;
        logic [7:0] irqBusyStatus;
        logic [7:0] attributes;
        logic [7:0] targetAddr;
        logic [7:0] dataHigh;
        logic [7:0] dataLow;
    } dli_eng_stat_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        nonBlocking;
        logic        wordSize;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } dli_win_req_s;

    typedef struct packed {
        logic errClear;
        logic irqClear;
    } dli_clr_s;

endpackage

/* dli_clk_div.sv */
`timescale 1ns/1ps
`include "dli_params.svh"

module dli_clk_div #(
    parameter int CNT_W = 4
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic       enable,
    input  wire logic       holdReq,
    input  wire logic [1:0] divSel,
    output logic            linkClk,
    output logic            halted
);

    localparam logic [CNT_W-1:0] HIGH_CNT = CNT_W'(`DLI_HIGH_CYC);
    localparam logic [CNT_W-1:0] BUS_CNT  = CNT_W'(`DLI_BUS_CYC);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lastCnt;

    // Period is (divSel+1) bus periods
    assign lastCnt = CNT_W'((CNT_W'(divSel) + CNT_W'(1)) * BUS_CNT - CNT_W'(1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt     <= '0;
            linkClk <= 1'b0;
            halted  <= 1'b0;
        end else if (ce) begin
            if (!enable) begin
                // low while disabled; restart on enable
                cnt     <= '0;
                linkClk <= 1'b0;
                halted  <= 1'b0;
            end else if (halted) begin
                halted  <= holdReq;
                cnt     <= '0;
                linkClk <= 1'b0;
            end else if (holdReq && (cnt == '0 || cnt >= HIGH_CNT)) begin
                halted  <= 1'b1;
                cnt     <= '0;
                linkClk <= 1'b0;
            end else begin
                // high phase half a bus period
                linkClk <= (cnt < HIGH_CNT);
                cnt     <= (cnt >= lastCnt) ? '0 : cnt + CNT_W'(1);
            end
        end
    end

endmodule

/* dli_initiator.sv */
`timescale 1ns/1ps
`include "dli_params.svh"

module dli_initiator #(
    parameter int ADDR_W  = 12,
    parameter int LINES   = 8,
    parameter int NARROW  = 4
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    input  wire logic                  specialMode,
    input  wire logic                  stopMode,
    input  wire logic                  waitMode,
    input  wire logic [ADDR_W-1:0]     address,
    input  wire logic [3:0]            byteenable,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    output dli_pkg::dli_cfg_s          cfg,
    input  wire dli_pkg::dli_eng_stat_s engStat,
    output dli_pkg::dli_win_req_s      winReq,
    input  wire logic                  winDone,
    input  wire logic [15:0]           winRdata,
    output dli_pkg::dli_clr_s          statClr,
    input  wire logic                  txActive,
    input  wire logic                  txDrive,
    input  wire logic [LINES-1:0]      txData,
    output logic      [LINES-1:0]      rxData,
    output logic                       targetIrq,
    input  wire logic [LINES-1:0]      linkDataLinesIn,
    input  wire logic                  targetIrqIn,
    output dli_pkg::dli_pins_s         pins
);

    dli_pkg::dli_bus_state_e state;
    dli_pkg::dli_bus_state_e next_state;
    dli_pkg::dli_pins_s      next_pins;
    dli_pkg::dli_win_req_s   next_winReq;

    logic       linkEnable;
    logic       linkWidthSel;
    logic       haltInWait;
    logic [1:0] linkClockDivider;
    logic       irqEnable;
    logic [3:0] timeout;

    logic       divClk;
    logic       divHalted;
    logic       holdReq;
    logic       locked;
    logic       busReq;
    logic [1:0] region;
    logic [2:0] regIdx;
    logic       regHit;
    logic       winHit;
    logic       regWrite;
    logic [7:0] wrByte;
    logic [31:0] next_readdata;
    logic [LINES-1:0] laneUsed;

    // Lane in use for the current width setting
    function automatic logic laneActive(input int lane, input logic en, input logic wide);
        laneActive = en && ((lane < NARROW) || wide);
    endfunction

    // Register read decode, reserved bits zero
    function automatic logic [7:0] regValue(input logic [2:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `DLI_IDX_CTL0: begin
                v[`DLI_BIT_ENABLE]   = linkEnable;
                v[`DLI_BIT_WIDE]     = linkWidthSel;
                v[`DLI_BIT_HALTWAIT] = haltInWait;
                v[`DLI_DIV_MSB:0]    = linkClockDivider;
                v = v & `DLI_CTL0_RDMASK;
            end
            `DLI_IDX_CTL1: begin
                v[`DLI_BIT_IRQ_ENABLE]  = irqEnable;
                v[`DLI_TIMEOUT_MSB:0]   = timeout;
                v = v & `DLI_CTL1_RDMASK;
            end
            `DLI_IDX_ERRSTAT: v = engStat.errStatus;
            `DLI_IDX_IRQSTAT: v = engStat.irqBusyStatus;
            `DLI_IDX_ATTR:    v = engStat.attributes;
            `DLI_IDX_TADDR:   v = engStat.targetAddr;
            `DLI_IDX_DATAHI:  v = engStat.dataHigh;
            `DLI_IDX_DATALO:  v = engStat.dataLow;
            default:          v = 8'h00;
        endcase
        regValue = v;
    endfunction

    assign busReq  = read || write;
    assign region  = address[11:10];
    assign regIdx  = address[4:2];
    assign regHit  = (region == `DLI_REGION_REGS) && (address[9:2] < `DLI_REGS_LIMIT);
    assign winHit  = (region == `DLI_REGION_BLOCKING) || (region == `DLI_REGION_NONBLOCK);
    assign wrByte  = writedata[7:0];
    assign regWrite = (state == dli_pkg::DLI_ANSWER) && write && regHit && byteenable[0];
    assign locked  = linkEnable && !specialMode;
    // stop, or wait with halt set
    assign holdReq = stopMode || (waitMode && haltInWait);

    dli_clk_div #(
        .CNT_W (4)
    ) u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .enable  (linkEnable),
        .holdReq (holdReq),
        .divSel  (linkClockDivider),
        .linkClk (divClk),
        .halted  (divHalted)
    );

    // Control register zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            linkEnable       <= 1'b0;
            linkWidthSel     <= 1'b0;
            haltInWait       <= 1'b0;
            linkClockDivider <= 2'h0;
        end else if (ce && regWrite && regIdx == `DLI_IDX_CTL0) begin
            haltInWait <= wrByte[`DLI_BIT_HALTWAIT];
            if (!locked) begin
                linkEnable       <= wrByte[`DLI_BIT_ENABLE];
                linkWidthSel     <= wrByte[`DLI_BIT_WIDE];
                linkClockDivider <= wrByte[`DLI_DIV_MSB:0];
            end
        end
    end

    // Control register one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqEnable <= 1'b0;
            timeout   <= 4'h0;
        end else if (ce && regWrite && regIdx == `DLI_IDX_CTL1) begin
            irqEnable <= wrByte[`DLI_BIT_IRQ_ENABLE];
            if (!locked) begin
                timeout <= wrByte[`DLI_TIMEOUT_MSB:0];
            end
        end
    end

    // Status clear strobes to the transaction engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            statClr <= '0;
        end else if (ce) begin
            statClr.errClear <= regWrite && (regIdx == `DLI_IDX_ERRSTAT)
                                && wrByte[`DLI_BIT_ERR_FLAG];
            statClr.irqClear <= regWrite && (regIdx == `DLI_IDX_IRQSTAT)
                                && wrByte[`DLI_BIT_IRQ_FLAG];
        end
    end

    // Configuration seen by the transaction engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg <= '0;
        end else if (ce) begin
            cfg.linkEnable       <= linkEnable;
            cfg.linkWidthSel     <= linkWidthSel;
            cfg.haltInWait       <= haltInWait;
            cfg.linkClockDivider <= linkClockDivider;
            cfg.irqEnable        <= irqEnable;
            cfg.timeout          <= timeout;
            cfg.linkHalted       <= divHalted;
        end
    end

    // Bus slave sequencing
    always_comb begin
        next_state    = state;
        next_readdata = readdata;
        next_winReq   = '0;
        case (state)
            dli_pkg::DLI_IDLE: begin
                if (busReq) begin
                    if (winHit && linkEnable) begin
                        next_state              = dli_pkg::DLI_WINDOW;
                        next_winReq.valid       = 1'b1;
                        next_winReq.write       = write;
                        next_winReq.nonBlocking = (region == `DLI_REGION_NONBLOCK);
                        next_winReq.wordSize    = byteenable[1];
                        next_winReq.addr        = address[9:2];
                        next_winReq.wdata       = writedata[15:0];
                    end else begin
                        next_state    = dli_pkg::DLI_ANSWER;
                        next_readdata = {24'h000000, regHit ? regValue(regIdx) : 8'h00};
                    end
                end
            end
            dli_pkg::DLI_WINDOW: begin
                if (winDone) begin
                    next_state    = dli_pkg::DLI_ANSWER;
                    next_readdata = {16'h0000, winRdata};
                end
            end
            dli_pkg::DLI_ANSWER: begin
                next_state = dli_pkg::DLI_IDLE;
            end
            default: begin
                next_state = dli_pkg::DLI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state       <= dli_pkg::DLI_IDLE;
            readdata    <= 32'h00000000;
            waitrequest <= 1'b1;
            winReq      <= '0;
        end else if (ce) begin
            state       <= next_state;
            readdata    <= next_readdata;
            waitrequest <= (next_state != dli_pkg::DLI_ANSWER);
            winReq      <= next_winReq;
        end
    end

    // Pin ownership and drive
    always_comb begin
        next_pins = '0;
        next_pins.ownClock     = linkEnable;
        // clock from divider; low when halted
        next_pins.linkClockOut = linkEnable && divClk;
        next_pins.ownIrq       = linkEnable;
        next_pins.irqPullDown  = linkEnable;
        for (int i = 0; i < LINES; i++) begin
            // four or eight data pins; upper lanes need wide mode
            laneUsed[i]                  = laneActive(i, linkEnable, linkWidthSel);
            next_pins.ownData[i]         = laneUsed[i];
            next_pins.linkDataLinesOeN[i] = 1'b1;
            if (laneUsed[i]) begin
                if (divHalted || !txActive) begin
                    next_pins.linkDataLinesOeN[i] = 1'b0;
                    next_pins.linkDataLinesOut[i] = 1'b0;
                end else if (txDrive) begin
                    next_pins.linkDataLinesOeN[i] = 1'b0;
                    next_pins.linkDataLinesOut[i] = txData[i];
                end else begin
                    next_pins.linkDataPullDown[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pins <= '0;
            pins.linkDataLinesOeN <= '1;
        end else if (ce) begin
            pins <= next_pins;
        end
    end

    // Sampled link inputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxData    <= '0;
            targetIrq <= 1'b0;
        end else if (ce) begin
            rxData    <= linkDataLinesIn & laneUsed;
            // active-high interrupt, used only when enabled
            targetIrq <= linkEnable && targetIrqIn;
        end
    end

endmodule

/* dli_checker.sv */
`timescale 1ns/1ps
module dli_checker #(
    parameter int ADDR_W = 12
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               ce,
    input  wire logic               stopMode,
    input  wire logic               waitMode,
    input  wire logic [ADDR_W-1:0]  address,
    input  wire logic               read,
    input  wire logic               waitrequest,
    input  wire dli_pkg::dli_cfg_s  cfg,
    input  wire logic               txActive,
    input  wire dli_pkg::dli_pins_s pins
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       run;
    logic       prevClk;
    logic       clean;
    logic [7:0] sinceRise;
    logic [7:0] lowRun;
    assign run = cfg.linkEnable && ce && !stopMode && !(waitMode && cfg.haltInWait);
    always_ff @(posedge clk) begin
        prevClk <= pins.linkClockOut && !sys_rst;
        if (sys_rst) begin
            sinceRise <= 8'h00;
            clean <= 1'b0;
        end else if (pins.linkClockOut && !prevClk) begin
            sinceRise <= 8'h01;
            clean <= run;
        end else begin
            sinceRise <= sinceRise + 8'h01;
            clean <= clean && run;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || !run || pins.linkClockOut) lowRun <= 8'h00;
        else if (lowRun != 8'hFF) lowRun <= lowRun + 8'h01;
    end
    sequence offSeq;
        !cfg.linkEnable [*3];
    endsequence
    sequence onSeq;
        cfg.linkEnable [*3];
    endsequence
    sequence holdSeq;
        (cfg.linkEnable && (stopMode || (waitMode && cfg.haltInWait))) [*6];
    endsequence
    chk_reset_idle: assert property ($fell(sys_rst) |-> !pins.linkClockOut &&
        pins.linkDataLinesOut == 8'h00 && waitrequest) else $error("outputs not idle after reset");
    chk_off_released: assert property (offSeq |-> pins.ownData == 8'h00 &&
        !pins.ownIrq && !pins.irqPullDown && !pins.linkClockOut) else $error("pins kept while off");
    chk_irq_pull: assert property (onSeq |-> pins.irqPullDown && pins.ownIrq)
        else $error("irq pull-down missing");
    chk_lane_width: assert property (onSeq |->
        pins.ownData == (cfg.linkWidthSel ? 8'hFF : 8'h0F)) else $error("wrong lanes owned");
    chk_input_pull: assert property (
        (pins.ownData & pins.linkDataLinesOeN & ~pins.linkDataPullDown) == 8'h00)
        else $error("input lane without pull-down");
    chk_idle_low: assert property ((cfg.linkEnable && !txActive) [*3] |->
        (pins.ownData & (pins.linkDataLinesOeN | pins.linkDataLinesOut)) == 8'h00)
        else $error("idle lanes not driven low");
    chk_hold_low: assert property (holdSeq |-> !pins.linkClockOut &&
        (pins.ownData & pins.linkDataLinesOut) == 8'h00) else $error("link not held low");
    chk_high_short: assert property ($rose(pins.linkClockOut) |=> !pins.linkClockOut)
        else $error("clock high phase too long");
    chk_clock_period: assert property (pins.linkClockOut && !prevClk && clean && run |->
        sinceRise == {5'h00, cfg.linkClockDivider, 1'b0} + 8'h02) else $error("bad clock period");
    chk_clock_alive: assert property (lowRun < 8'h0C)
        else $error("clock stalled while running");
    chk_reg_answer: assert property (read && waitrequest && address[ADDR_W-1:5] == '0 |->
        ##[1:2] !waitrequest) else $error("register read not answered");
    chk_answer_once: assert property (!waitrequest |=> waitrequest)
        else $error("answer longer than one cycle");
endmodule

bind dli_initiator dli_checker #(.ADDR_W(ADDR_W)) chk (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .stopMode(stopMode), .waitMode(waitMode), .address(address), .read(read),
    .waitrequest(waitrequest), .cfg(cfg), .txActive(txActive), .pins(pins));

/* dli_target_model.sv */
`timescale 1ns/1ps
module dli_target_model (
    input  wire logic               clk,
    input  wire dli_pkg::dli_pins_s pins,
    input  wire logic               tgtDrive,
    input  wire logic [7:0]         tgtData,
    input  wire logic               tgtIrq,
    output logic      [7:0]         linkDataLinesIn,
    output logic                    targetIrqIn
);
    logic [7:0] lastLevel;
    assign targetIrqIn = tgtIrq;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pins.linkDataLinesOeN[i]) linkDataLinesIn[i] = pins.linkDataLinesOut[i];
            else if (tgtDrive) linkDataLinesIn[i] = tgtData[i];
            else if (pins.linkDataPullDown[i]) linkDataLinesIn[i] = 1'b0;
            else linkDataLinesIn[i] = ~lastLevel[i];
        end
    end
    always_ff @(posedge clk) lastLevel <= linkDataLinesIn;
endmodule

/* test_die_link_initiator_pins_clock.sv */
`timescale 1ns/1ps
module test_die_link_initiator_pins_clock;
    logic clk = 0, sys_rst = 1, ce = 1, specialMode = 0, stopMode = 0, waitMode = 0;
    logic read = 0, write = 0, winDone = 0, txActive = 0, txDrive = 0;
    logic tgtDrive = 0, tgtIrq = 0, waitrequest, targetIrq, targetIrqIn;
    logic [11:0] address = 0;
    logic [31:0] writedata = 0, readdata;
    logic [7:0] txData = 0, tgtData = 0, rxData, linkDataLinesIn;
    dli_pkg::dli_cfg_s cfg;
    dli_pkg::dli_eng_stat_s engStat = {8'h81, 8'h40, 8'h93, 8'h5A, 8'hC3, 8'h3C};
    dli_pkg::dli_win_req_s winReq, lastReq;
    dli_pkg::dli_clr_s statClr;
    dli_pkg::dli_pins_s pins;
    int doneCnt = 0, mismatches = 0, samples_checked = 0;

    always #4 clk = ~clk;

    dli_initiator dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .specialMode(specialMode),
        .stopMode(stopMode), .waitMode(waitMode), .address(address), .byteenable(4'hF),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .cfg(cfg), .engStat(engStat), .winReq(winReq),
        .winDone(winDone), .winRdata(16'hBEEF), .statClr(statClr), .txActive(txActive),
        .txDrive(txDrive), .txData(txData), .rxData(rxData), .targetIrq(targetIrq),
        .linkDataLinesIn(linkDataLinesIn), .targetIrqIn(targetIrqIn), .pins(pins));

    dli_target_model target (.clk(clk), .pins(pins), .tgtDrive(tgtDrive), .tgtData(tgtData),
        .tgtIrq(tgtIrq), .linkDataLinesIn(linkDataLinesIn), .targetIrqIn(targetIrqIn));

    // Engine stand-in answers window accesses three cycles later
    always @(posedge clk) begin
        winDone <= (doneCnt == 1);
        if (winReq.valid) lastReq <= winReq;
        doneCnt <= winReq.valid ? 3 : (doneCnt != 0 ? doneCnt - 1 : 0);
    end

    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic settle(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(negedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(nm, q, e);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic period(input int exp);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (pins.linkClockOut !== 1'b1 && n < 40);
        end
        check("clock period", n, exp);
        if (n >= 40) wrap_up();
    endtask

    task automatic hold(input logic s, input logic w, input logic expRun);
        int highs;
        highs = 0;
        @(posedge clk);
        stopMode <= s;
        waitMode <= w;
        txActive <= 1'b1;
        settle(8);
        repeat (16) begin
            @(negedge clk);
            if (pins.linkClockOut === 1'b1) highs++;
        end
        check("clock running", highs != 0, expRun);
        check("halted flag", cfg.linkHalted, !expRun);
        check("held data", {pins.linkDataLinesOeN[3:0], pins.linkDataLinesOut[3:0]},
              expRun ? 32'hF0 : 32'h00);
        @(posedge clk);
        stopMode <= 1'b0;
        waitMode <= 1'b0;
        txActive <= 1'b0;
        settle(8);
        check("woken data", pins.linkDataLinesOeN[3:0], 32'h0);
        period(6);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rd(12'h000, 32'h00, "control zero");
        check("clock at reset", pins.linkClockOut, 32'h0);
        wr(12'h000, 32'h3D);
        rd(12'h000, 32'h21, "reserved bits");
        rd(12'h040, 32'h0, "unmapped");
        rd(12'h400, 32'h0, "window while off");
        wr(12'h000, 32'h82);
        settle(8);
        check("narrow lanes", pins.ownData, 32'h0F);
        check("irq pull-down", pins.irqPullDown, 32'h1);
        period(6);
        wr(12'h000, 32'hE3);
        rd(12'h000, 32'hA2, "locked fields");
        hold(1'b1, 1'b0, 1'b0);
        hold(1'b0, 1'b1, 1'b0);
        wr(12'h000, 32'h82);
        hold(1'b0, 1'b1, 1'b1);
        @(posedge clk);
        txActive <= 1'b1;
        txDrive <= 1'b1;
        txData <= 8'hA5;
        settle(4);
        check("driven lanes", {pins.linkDataLinesOeN[3:0], pins.linkDataLinesOut[3:0]}, 32'h05);
        @(posedge clk);
        txDrive <= 1'b0;
        tgtDrive <= 1'b1;
        tgtData <= 8'h3C;
        tgtIrq <= 1'b1;
        settle(4);
        check("received lanes", rxData, 32'h0C);
        check("target irq", targetIrq, 32'h1);
        @(posedge clk);
        tgtDrive <= 1'b0;
        txActive <= 1'b0;
        tgtIrq <= 1'b0;
        settle(4);
        check("idle lanes", pins.linkDataLinesOeN[3:0], 32'h0);
        rd(12'h404, 32'hBEEF, "blocking window");
        check("read request", {lastReq.write, lastReq.nonBlocking, lastReq.addr}, 32'h001);
        wr(12'h808, 32'h1234);
        check("write request", {lastReq.write, lastReq.nonBlocking, lastReq.addr, lastReq.wdata},
              {6'h00, 2'b11, 8'h02, 16'h1234});
        rd(12'h01C, 32'h3C, "data low");
        wr(12'h004, 32'h8F);
        rd(12'h004, 32'h80, "control one");
        wr(12'h008, 32'h80);
        settle(1);
        check("error clear", {statClr.errClear, statClr.irqClear}, 32'h2);
        wr(12'h00C, 32'h80);
        settle(1);
        check("irq clear", {statClr.errClear, statClr.irqClear}, 32'h1);
        @(posedge clk);
        specialMode <= 1'b1;
        wr(12'h000, 32'h43);
        rd(12'h000, 32'h43, "special rewrite");
        wr(12'h004, 32'h05);
        rd(12'h004, 32'h05, "special timeout");
        check("config copy", {cfg.irqEnable, cfg.timeout}, 32'h05);
        settle(6);
        check("released pins", {pins.ownData, pins.linkClockOut}, 32'h0);
        wr(12'h000, 32'hC3);
        settle(8);
        check("wide lanes", pins.ownData, 32'hFF);
        period(8);
        wrap_up();
    end

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule
